// file: logic/io_pin_mux.sv
/*
 * per-pin output source and driver enable, registered.
 * assumes peripheral and analog enables are synchronous to clk_in.
 */
`timescale 1ns/1ps
module io_pin_mux
    import io_port_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    pin_ctrl_if.mux               ctrl,
    input  wire logic [PIN_W-1:0] periph_sel_in,
    input  wire logic [PIN_W-1:0] periph_data_in,
    input  wire logic [PIN_W-1:0] analog_out_en_in,
    output logic      [PIN_W-1:0] pin_out,
    output logic      [PIN_W-1:0] pin_oe_out
);
    logic [PIN_W-1:0] data_d;
    logic [PIN_W-1:0] oe_d;

    // source select: latch, then peripheral, then analog forces off
    always_comb begin
        data_d = (ctrl.latch & ~periph_sel_in) | (periph_data_in & periph_sel_in);
        oe_d   = ~ctrl.dir & ~analog_out_en_in;
        oe_d   = oe_d & ~(ctrl.od & data_d);     // open drain only sinks
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pin_out    <= RST_LATCH;
            pin_oe_out <= RST_ZERO;
        end else begin
            pin_out    <= data_d;
            pin_oe_out <= oe_d;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    property p_analog_hiz;
        |analog_out_en_in |=> (pin_oe_out & $past(analog_out_en_in)) == RST_ZERO;
    endproperty
    a_analog_hiz: assert property (p_analog_hiz) else $error("analog output pin still driven");

    property p_periph_src;
        |periph_sel_in |=> ((pin_out ^ $past(periph_data_in)) & $past(periph_sel_in)) == RST_ZERO;
    endproperty
    a_periph_src: assert property (p_periph_src) else $error("peripheral data not on pin");

    property p_latch_src;
        periph_sel_in == RST_ZERO |=> pin_out == $past(ctrl.latch);
    endproperty
    a_latch_src: assert property (p_latch_src) else $error("latch data not on pin");
endmodule

// file: logic/io_port_pin_control.sv
/*
 * one eight-pin general-purpose i/o port: ten port registers plus
 * the limited-drive configuration, output multiplexer, pin read path.
 * assumes a single-cycle register port and pins sampled on clk_in.
 */
// The strobed register port and the placing of the registers are this design's own decisions.
//
// Operation
// - ten standard registers per port
// - peripheral owns pin, level still readable
// - latch write equals pin-level write
// - latch reads latch, pin-level reads pins
// - analog select disables digital input buffer
// - limited drive only with per-pin enables
// - limiting independent of output source
// - one global enable and current select
// - separate source and sink enables
// - after reset pins undriven, direction all input
// - peripherals reach pin via pin select
// - analog inputs active only in analog mode
// - analog select leaves digital driver on
// - analog output forces driver off
// - select 11/10/01/00 = 1/2/5/10 mA
// - direction set is input, clear drives latch
// - analog pins read zero as digital
`timescale 1ns/1ps
module io_port_pin_control
    import io_port_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic               srst_in,
    // register port
    input  wire logic [ADDR_W-1:0]  addr_in,
    input  wire logic [PIN_W-1:0]   wdata_in,
    input  wire logic               wr_in,
    input  wire logic               rd_in,
    output logic      [PIN_W-1:0]   rdata_out,
    // pins
    input  wire logic [PIN_W-1:0]   pin_in,
    output logic      [PIN_W-1:0]   pin_out,
    output logic      [PIN_W-1:0]   pin_oe_out,
    // peripherals and analog
    input  wire logic [PIN_W-1:0]   periph_sel_in,
    input  wire logic [PIN_W-1:0]   periph_data_in,
    input  wire logic [PIN_W-1:0]   analog_out_en_in,
    output logic      [PIN_W-1:0]   digital_in_out,
    output logic      [PIN_W-1:0]   analog_in_en_out,
    // pad controls
    output logic      [PIN_W-1:0]   pullup_en_out,
    output logic      [PIN_W-1:0]   threshold_out,
    output logic      [PIN_W-1:0]   slew_limit_out,
    output logic      [PIN_W-1:0]   src_limit_out,
    output logic      [PIN_W-1:0]   snk_limit_out,
    output logic      [TENTH_W-1:0] limit_tenths_out
);

    logic [PIN_W-1:0] latch_q;
    logic [PIN_W-1:0] latch_d;
    logic [PIN_W-1:0] dir_q;
    logic [PIN_W-1:0] dir_d;
    logic [PIN_W-1:0] analog_q;
    logic [PIN_W-1:0] analog_d;
    logic [PIN_W-1:0] pullup_q;
    logic [PIN_W-1:0] pullup_d;
    logic [PIN_W-1:0] src_en_q;
    logic [PIN_W-1:0] src_en_d;
    logic [PIN_W-1:0] snk_en_q;
    logic [PIN_W-1:0] snk_en_d;
    logic [PIN_W-1:0] thresh_q;
    logic [PIN_W-1:0] thresh_d;
    logic [PIN_W-1:0] slew_q;
    logic [PIN_W-1:0] slew_d;
    logic [PIN_W-1:0] od_q;
    logic [PIN_W-1:0] od_d;
    logic             glob_en_q;
    logic             glob_en_d;
    logic [1:0]       sel_q;
    logic [1:0]       sel_d;
    logic [PIN_W-1:0] pin_q;
    logic [PIN_W-1:0] pin_read;
    logic [PIN_W-1:0] rdata_d;
    logic [PIN_W-1:0] cfg_read;

    pin_ctrl_if ctrl ();

    // control bits out to the multiplexer and limit gating
    assign ctrl.latch   = latch_q;
    assign ctrl.dir     = dir_q;
    assign ctrl.od      = od_q;
    assign ctrl.src_en  = src_en_q;
    assign ctrl.snk_en  = snk_en_q;
    assign ctrl.glob_en = glob_en_q;
    assign ctrl.sel     = sel_q;

    // digital input buffer off for analog pins
    assign pin_read = pin_q & ~analog_q;

    // limited-drive config as software sees it, unused bits zero
    always_comb begin
        cfg_read              = RST_ZERO;
        cfg_read[CFG_EN_BIT]  = glob_en_q;
        cfg_read[CFG_SEL_MSB:CFG_SEL_LSB] = sel_q;
    end

    // register writes
    always_comb begin
        latch_d   = latch_q;
        dir_d     = dir_q;
        analog_d  = analog_q;
        pullup_d  = pullup_q;
        src_en_d  = src_en_q;
        snk_en_d  = snk_en_q;
        thresh_d  = thresh_q;
        slew_d    = slew_q;
        od_d      = od_q;
        glob_en_d = glob_en_q;
        sel_d     = sel_q;
        if (wr_in) begin
            unique case (addr_in)
                OFS_PIN_LEVEL,
                OFS_LATCH: begin
                    latch_d = wdata_in;
                end
                OFS_DIRECTION: begin
                    dir_d = wdata_in;
                end
                OFS_ANALOG: begin
                    analog_d = wdata_in;
                end
                OFS_PULLUP: begin
                    pullup_d = wdata_in;
                end
                OFS_SRC_LIMIT: begin
                    src_en_d = wdata_in;
                end
                OFS_SNK_LIMIT: begin
                    snk_en_d = wdata_in;
                end
                OFS_THRESHOLD: begin
                    thresh_d = wdata_in;
                end
                OFS_SLEW: begin
                    slew_d = wdata_in;
                end
                OFS_OPEN_DRAIN: begin
                    od_d = wdata_in;
                end
                OFS_LIMIT_CFG: begin
                    glob_en_d = wdata_in[CFG_EN_BIT];
                    sel_d     = wdata_in[CFG_SEL_MSB:CFG_SEL_LSB];
                end
                default: begin
                    latch_d = latch_q; // unmapped write ignored
                end
            endcase
        end
    end

    // register read, data valid the cycle after the strobe only
    always_comb begin
        rdata_d = RST_ZERO;
        if (rd_in) begin
            unique case (addr_in)
                OFS_PIN_LEVEL:  rdata_d = pin_read;
                OFS_LATCH:      rdata_d = latch_q;
                OFS_DIRECTION:  rdata_d = dir_q;
                OFS_ANALOG:     rdata_d = analog_q;
                OFS_PULLUP:     rdata_d = pullup_q;
                OFS_SRC_LIMIT:  rdata_d = src_en_q;
                OFS_SNK_LIMIT:  rdata_d = snk_en_q;
                OFS_THRESHOLD:  rdata_d = thresh_q;
                OFS_SLEW:       rdata_d = slew_q;
                OFS_OPEN_DRAIN: rdata_d = od_q;
                OFS_LIMIT_CFG:  rdata_d = cfg_read;
                default:        rdata_d = RST_ZERO;
            endcase
        end
    end

    // register state, pin sample and read data
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            latch_q   <= RST_LATCH;
            dir_q     <= RST_DIR;
            analog_q  <= RST_ANALOG;
            pullup_q  <= RST_ZERO;
            src_en_q  <= RST_ZERO;
            snk_en_q  <= RST_ZERO;
            thresh_q  <= RST_ZERO;
            slew_q    <= RST_ZERO;
            od_q      <= RST_ZERO;
            glob_en_q <= 1'b0;
            sel_q     <= SEL_10MA;
            pin_q     <= RST_ZERO;
            rdata_out <= RST_ZERO;
        end else begin
            latch_q   <= latch_d;
            dir_q     <= dir_d;
            analog_q  <= analog_d;
            pullup_q  <= pullup_d;
            src_en_q  <= src_en_d;
            snk_en_q  <= snk_en_d;
            thresh_q  <= thresh_d;
            slew_q    <= slew_d;
            od_q      <= od_d;
            glob_en_q <= glob_en_d;
            sel_q     <= sel_d;
            pin_q     <= pin_in;
            rdata_out <= rdata_d;
        end
    end

    // pad control levels straight from their registers, digital input is the pin sample masked by analog select
    assign pullup_en_out    = pullup_q;
    assign threshold_out    = thresh_q;
    assign slew_limit_out   = slew_q;
    assign analog_in_en_out = analog_q;
    assign digital_in_out   = pin_read;

    // output source select and driver enable
    io_pin_mux u_mux (
        .clk_in           (clk_in),
        .srst_in          (srst_in),
        .ctrl             (ctrl.mux),
        .periph_sel_in    (periph_sel_in),
        .periph_data_in   (periph_data_in),
        .analog_out_en_in (analog_out_en_in),
        .pin_out          (pin_out),
        .pin_oe_out       (pin_oe_out)
    );

    // limited drive, independent of the source select
    limit_drive_gate u_limit (
        .clk_in           (clk_in),
        .srst_in          (srst_in),
        .ctrl             (ctrl.limit),
        .src_limit_out    (src_limit_out),
        .snk_limit_out    (snk_limit_out),
        .limit_tenths_out (limit_tenths_out)
    );

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence s_wr_latch;
        wr_in && (addr_in == OFS_LATCH || addr_in == OFS_PIN_LEVEL);
    endsequence

    sequence s_rd_latch;
        rd_in && addr_in == OFS_LATCH;
    endsequence

    property p_latch_write;
        s_wr_latch |=> latch_q == $past(wdata_in);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch not written");

    property p_write_read;
        s_wr_latch ##1 s_rd_latch |=> rdata_out == $past(wdata_in, 2);
    endproperty
    a_write_read: assert property (p_write_read) else $error("latch read back wrong");

    property p_pin_read;
        rd_in && addr_in == OFS_PIN_LEVEL |=> rdata_out == ($past(pin_q) & ~$past(analog_q));
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin level read wrong");

    property p_analog_zero;
        analog_q == RST_ANALOG && rd_in && addr_in == OFS_PIN_LEVEL |=> rdata_out == RST_ZERO;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

    property p_input_buffer;
        (digital_in_out & analog_q) == RST_ZERO;
    endproperty
    a_input_buffer: assert property (p_input_buffer) else $error("analog pin input buffer on");

    property p_dir_input;
        dir_q == RST_DIR ##1 dir_q == RST_DIR |-> pin_oe_out == RST_ZERO;
    endproperty
    a_dir_input: assert property (p_dir_input) else $error("input pin driven");

    property p_analog_drives;
        dir_q == RST_ZERO && od_q == RST_ZERO && analog_out_en_in == RST_ZERO
            |=> pin_oe_out == RST_DIR;
    endproperty
    a_analog_drives: assert property (p_analog_drives) else $error("output driver off");

    property p_rd_idle;
        !rd_in |=> rdata_out == RST_ZERO;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

endmodule

// file: logic/io_port_pkg.sv
/*
 * constants for one eight-pin general-purpose i/o port:
 * register offsets, reset values, config fields, drive levels.
 * assumes a byte-wide register port with a four-bit address.
 */
package io_port_pkg;

    localparam int PIN_W  = 8;
    localparam int ADDR_W = 4;
    localparam int TENTH_W = 7;

    // register offsets on the register port
    localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_LATCH      = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_ANALOG     = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_PULLUP     = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_SRC_LIMIT  = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_SNK_LIMIT  = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_THRESHOLD  = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_SLEW       = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_LIMIT_CFG  = 4'hA;

    // reset values
    localparam logic [PIN_W-1:0] RST_LATCH  = 8'h00;
    localparam logic [PIN_W-1:0] RST_DIR    = 8'hFF;
    localparam logic [PIN_W-1:0] RST_ANALOG = 8'hFF;
    localparam logic [PIN_W-1:0] RST_ZERO   = 8'h00;

    // limit_drive_config fields
    localparam int CFG_EN_BIT  = 7;
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_SEL_MSB = 1;

    // limit_current_select codes and their currents in tenths of a mA
    localparam logic [1:0] SEL_1MA  = 2'h3;
    localparam logic [1:0] SEL_2MA  = 2'h2;
    localparam logic [1:0] SEL_5MA  = 2'h1;
    localparam logic [1:0] SEL_10MA = 2'h0;
    localparam logic [TENTH_W-1:0] TENTHS_1MA  = 7'h0A;
    localparam logic [TENTH_W-1:0] TENTHS_2MA  = 7'h14;
    localparam logic [TENTH_W-1:0] TENTHS_5MA  = 7'h32;
    localparam logic [TENTH_W-1:0] TENTHS_10MA = 7'h64;

    // maps a current-select code to its limit in tenths of a mA
    function automatic logic [TENTH_W-1:0] limit_tenths(input logic [1:0] sel);
        logic [TENTH_W-1:0] t;
        unique case (sel)
            SEL_1MA: t = TENTHS_1MA;
            SEL_2MA: t = TENTHS_2MA;
            SEL_5MA: t = TENTHS_5MA;
            SEL_10MA: t = TENTHS_10MA;
        endcase
        return t;
    endfunction

endpackage

// file: logic/limit_drive_gate.sv
/*
 * current-limited drive gating under the global enable.
 * assumes software keeps per-pin enables clear while global is off.
 */
`timescale 1ns/1ps
module limit_drive_gate
    import io_port_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic               srst_in,
    pin_ctrl_if.limit               ctrl,
    output logic      [PIN_W-1:0]   src_limit_out,
    output logic      [PIN_W-1:0]   snk_limit_out,
    output logic      [TENTH_W-1:0] limit_tenths_out
);
    logic [PIN_W-1:0]   src_d;
    logic [PIN_W-1:0]   snk_d;
    logic [TENTH_W-1:0] tenths_d;

    // per-pin enables apply only with the global enable set
    always_comb begin
        src_d    = ctrl.src_en & {PIN_W{ctrl.glob_en}};
        snk_d    = ctrl.snk_en & {PIN_W{ctrl.glob_en}};
        tenths_d = limit_tenths(ctrl.sel);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            src_limit_out    <= RST_ZERO;
            snk_limit_out    <= RST_ZERO;
            limit_tenths_out <= TENTHS_10MA;
        end else begin
            src_limit_out    <= src_d;
            snk_limit_out    <= snk_d;
            limit_tenths_out <= tenths_d;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    property p_global_gate;
        !ctrl.glob_en |=> (src_limit_out | snk_limit_out) == RST_ZERO;
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("limit active without global enable");

    property p_one_ma;
        ctrl.sel == SEL_1MA |=> limit_tenths_out == TENTHS_1MA;
    endproperty
    a_one_ma: assert property (p_one_ma) else $error("code 11 not 1.0 mA");
endmodule

// file: logic/pin_ctrl_if.sv
/*
 * carrier for the port control bits between the register block,
 * the output multiplexer and the limited-drive gating.
 * assumes all three sit on the same clock.
 */
`timescale 1ns/1ps
interface pin_ctrl_if;
    import io_port_pkg::*;
    logic [PIN_W-1:0]   latch;
    logic [PIN_W-1:0]   dir;
    logic [PIN_W-1:0]   od;
    logic [PIN_W-1:0]   src_en;
    logic [PIN_W-1:0]   snk_en;
    logic               glob_en;
    logic [1:0]         sel;
    modport regs  (output latch, dir, od, src_en, snk_en, glob_en, sel);
    modport mux   (input latch, dir, od);
    modport limit (input src_en, snk_en, glob_en, sel);
endinterface

// file: verif/io_port_pin_control_test.sv
/*
 * self-checking bench for the eight-pin i/o port block.
 * assumes single-cycle register port, read data one cycle later.
 */
`timescale 1ns/1ps
module io_port_pin_control_test;
    import io_port_pkg::*;
    logic               clk_in = 1'b0;
    logic               srst_in = 1'b1;
    logic [ADDR_W-1:0]  addr_in = '0;
    logic [PIN_W-1:0]   wdata_in = '0;
    logic               wr_in = 1'b0;
    logic               rd_in = 1'b0;
    logic [PIN_W-1:0]   periph_sel = '0;
    logic [PIN_W-1:0]   periph_data = '0;
    logic [PIN_W-1:0]   aout_en = '0;
    logic [PIN_W-1:0]   ext_en = '0;
    logic [PIN_W-1:0]   ext_val = '0;
    logic [PIN_W-1:0]   pin_lvl, rdata, pout, poe, din, ain, pu, thr, slw, srcl, snkl;
    logic [TENTH_W-1:0] tenths;
    int                 n_fail = 0;
    int                 tests_run = 0;

    always #25 clk_in = ~clk_in;

    io_port_pin_control dut (
        .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .pin_in(pin_lvl),
        .pin_out(pout), .pin_oe_out(poe), .periph_sel_in(periph_sel),
        .periph_data_in(periph_data), .analog_out_en_in(aout_en),
        .digital_in_out(din), .analog_in_en_out(ain), .pullup_en_out(pu),
        .threshold_out(thr), .slew_limit_out(slw), .src_limit_out(srcl),
        .snk_limit_out(snkl), .limit_tenths_out(tenths));

    pin_partner pads (
        .clk_in(clk_in), .drive_in(pout), .oe_in(poe), .pullup_in(pu),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_lvl));

    // counts and verdict, the single end of the run
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [PIN_W-1:0] got, input logic [PIN_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [PIN_W-1:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    // one-cycle read strobe, data judged in the following cycle
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [PIN_W-1:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    // write then read back from the latch with no idle cycle between strobes
    task automatic wr_rchk(input logic [ADDR_W-1:0] a, input logic [PIN_W-1:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        addr_in <= OFS_LATCH;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata, d);
    endtask

    // registered outputs need a few edges to follow
    task automatic settle();
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    // reset contents of every offset, plus an unmapped one
    task automatic t_reset();
        for (int i = 0; i < 12; i++) begin
            rchk(4'(i), (i == 2 || i == 3) ? 8'hFF : 8'h00);
        end
        chk(poe, 8'h00);
        chk(pout, 8'h00);
        chk({1'b0, tenths}, {1'b0, TENTHS_10MA});
        $display("test reset done");
    endtask

    // latch versus pin level, direction
    task automatic t_latch();
        wr(OFS_ANALOG, 8'h00);
        wr(OFS_DIRECTION, 8'h00);
        wr(OFS_PIN_LEVEL, 8'hA5);
        rchk(OFS_LATCH, 8'hA5);
        settle();
        chk(pout, 8'hA5);
        chk(poe, 8'hFF);
        wr(OFS_LATCH, 8'h3C);
        settle();
        rchk(OFS_PIN_LEVEL, 8'h3C);
        ext_en <= 8'hFF;
        ext_val <= 8'h5A;
        wr(OFS_DIRECTION, 8'hFF);
        settle();
        chk(poe, 8'h00);
        rchk(OFS_PIN_LEVEL, 8'h5A);
        rchk(OFS_LATCH, 8'h3C);
        $display("test latch done");
    endtask

    // analog select on half the pins, still driven
    task automatic t_analog();
        wr(OFS_ANALOG, 8'h0F);
        settle();
        chk(din, 8'h50);
        chk(ain, 8'h0F);
        rchk(OFS_PIN_LEVEL, 8'h50);
        ext_en <= 8'h00;
        wr(OFS_DIRECTION, 8'h00);
        settle();
        chk(poe, 8'hFF);
        chk(pout, 8'h3C);
        wr(OFS_ANALOG, 8'h00);
        $display("test analog done");
    endtask

    // pin-select peripheral and analog output priority
    task automatic t_periph();
        wr(OFS_LATCH, 8'h00);
        periph_sel <= 8'hF0;
        periph_data <= 8'hCC;
        settle();
        chk(pout, 8'hC0);
        rchk(OFS_PIN_LEVEL, 8'hC0);
        wr(OFS_LATCH, 8'hFF);
        settle();
        chk(pout, 8'hCF);
        @(posedge clk_in);
        aout_en <= 8'h81;
        settle();
        chk(poe, 8'h7E);
        @(posedge clk_in);
        aout_en <= 8'h00;
        periph_sel <= 8'h00;
        $display("test periph done");
    endtask

    // limit current codes, per-pin source and sink enables
    task automatic t_limit();
        logic [TENTH_W-1:0] tab [4];
        tab = '{TENTHS_10MA, TENTHS_5MA, TENTHS_2MA, TENTHS_1MA};
        for (int s = 0; s < 4; s++) begin
            wr(OFS_LIMIT_CFG, 8'h80 | 8'(s));
            settle();
            chk({1'b0, tenths}, {1'b0, tab[s]});
            rchk(OFS_LIMIT_CFG, 8'h80 | 8'(s));
        end
        // global enable set before any per-pin enable
        wr(OFS_SRC_LIMIT, 8'h0F);
        wr(OFS_SNK_LIMIT, 8'hF0);
        periph_sel <= 8'h3C;
        settle();
        chk(srcl, 8'h0F);
        chk(snkl, 8'hF0);
        wr(OFS_SRC_LIMIT, 8'h00);
        settle();
        chk(srcl, 8'h00);
        chk(snkl, 8'hF0);
        wr(OFS_SNK_LIMIT, 8'h00);
        wr(OFS_LIMIT_CFG, 8'h00);
        periph_sel <= 8'h00;
        $display("test limit done");
    endtask

    // pad registers, open drain, unmapped place
    task automatic t_pad();
        wr(OFS_PULLUP, 8'hFF);
        wr(OFS_THRESHOLD, 8'h96);
        wr(OFS_SLEW, 8'h69);
        wr(OFS_OPEN_DRAIN, 8'hFF);
        wr_rchk(OFS_LATCH, 8'h0F);
        wr(4'hC, 8'hFF);
        settle();
        chk(pu, 8'hFF);
        chk(thr, 8'h96);
        chk(slw, 8'h69);
        chk(poe, 8'hF0);
        rchk(OFS_PIN_LEVEL, 8'h0F);
        rchk(OFS_OPEN_DRAIN, 8'hFF);
        rchk(4'hC, 8'h00);
        $display("test pad done");
    endtask

    // reset in mid-run: latch, direction and pins back to defaults
    task automatic t_rerun();
        @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        #1;
        chk(pout, 8'h00);
        chk(poe, 8'h00);
        rchk(OFS_LATCH, 8'h00);
        rchk(OFS_DIRECTION, 8'hFF);
        $display("test rerun done");
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        print_verdict();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        t_reset();
        t_latch();
        t_analog();
        t_periph();
        t_limit();
        t_pad();
        t_rerun();
        print_verdict();
    end
endmodule

// file: verif/pin_partner.sv
/*
 * model of the pads and whatever drives them from outside the chip.
 * assumes registered pin drive and enable from the port block.
 */
`timescale 1ns/1ps
module pin_partner
    import io_port_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic [PIN_W-1:0] drive_in,
    input  wire logic [PIN_W-1:0] oe_in,
    input  wire logic [PIN_W-1:0] pullup_in,
    input  wire logic [PIN_W-1:0] ext_en_in,
    input  wire logic [PIN_W-1:0] ext_val_in,
    output logic      [PIN_W-1:0] level_out
);
    logic [PIN_W-1:0] last_q;

    // pad wins if driven, then outside driver, then pull-up
    always_comb begin
        for (int i = 0; i < PIN_W; i++) begin
            if (oe_in[i]) begin
                level_out[i] = drive_in[i];
            end else if (ext_en_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else if (pullup_in[i]) begin
                level_out[i] = 1'b1;
            end else begin
                level_out[i] = ~last_q[i]; // floating line wanders
            end
        end
    end

    // last seen level, so a floating pin never repeats it
    always_ff @(posedge clk_in) begin
        last_q <= level_out;
    end
endmodule
